// ===== rtl/tcf_consts.svh
`ifndef TCF_CONSTS_SVH
`define TCF_CONSTS_SVH
// Register word indices (byte address = index * 4)
`define TCF_IDX_LOW      2'h0
`define TCF_IDX_HIGH     2'h1
`define TCF_IDX_CTRL     2'h2
`define TCF_IDX_STAT     2'h3
// Scheme-select encodings
`define TCF_MODE_BARE    4'h0
`define TCF_MODE_P32     4'h1
`define TCF_MODE_P39     4'h8
`define TCF_MODE_P48     4'h9
// Wide register layout
`define TCF_W64_MODE_HI  63
`define TCF_W64_MODE_LO  60
`define TCF_W64_ASID_HI  59
`define TCF_W64_ASID_LO  44
`define TCF_W64_PPN_HI   43
// Narrow register layout
`define TCF_W32_MODE     31
`define TCF_W32_ASID_HI  30
`define TCF_W32_ASID_LO  22
`define TCF_W32_PPN_HI   21
// Implemented widths
`define TCF_ASID_IMPL    16'h007F
`define TCF_ASID_MAX32   16'h01FF
`define TCF_ASID_MAX64   16'hFFFF
`define TCF_PPN_IMPL     44'h000003FFFFF
// Fence encoding
`define TCF_OP_SYSTEM    7'h73
`define TCF_F3_PRIV      3'h0
`define TCF_F7_FENCE     7'h09
`define TCF_REG_ZERO     5'h00
// Control and status bits
`define TCF_CTRL_W64     0
`define TCF_CTRL_FULL    1
`define TCF_STAT_BUSY    0
`define TCF_STAT_DISC    1
`define TCF_STAT_XLATE   2
`define TCF_CTRL_RESET   2'h1
`endif

// ===== rtl/tcf_pkg.sv
package tcf_pkg;
    // Fence sequencer, Gray along idle-drain-flush-done
    typedef enum logic [1:0] {
        tcf_idle  = 2'b00,
        tcf_drain = 2'b01,
        tcf_flush = 2'b11,
        tcf_done  = 2'b10
    } tcf_fence_state_t;
endpackage

// ===== rtl/tcf_translation_control.sv
`timescale 1ns/100ps
`include "tcf_consts.svh"
module tcf_translation_control (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        fence_valid,
    input  wire logic [31:0] fence_instr,
    input  wire logic [63:0] fence_vaddr_operand,
    input  wire logic [63:0] fence_space_id_operand,
    output logic             fence_ready,
    output logic             fence_done,
    input  wire logic        stores_drained,
    output logic             flush_req,
    input  wire logic        flush_ack,
    output logic             flush_all_levels,
    output logic             flush_match_space_id,
    output logic [63:0]      flush_vaddr,
    output logic [15:0]      flush_space_id,
    output logic             xlate_active,
    output logic [3:0]       xlate_scheme,
    output logic [43:0]      root_table_page_number,
    output logic [15:0]      xlate_space_id
);

    // Architectural state
    logic [3:0]  mode_q;
    logic [15:0] asid_q;
    logic [43:0] ppn_q;
    logic [31:0] stage_low;
    logic        w64_q;
    logic        full_q;
    logic        discard_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    // Control register reset image
    localparam logic [1:0] ctrl_reset_val = `TCF_CTRL_RESET;
    tcf_pkg::tcf_fence_state_t state;
    tcf_pkg::tcf_fence_state_t next_state;

    // Bus request decode
    wire         wb_req   = wb_cyc_i & wb_stb_i & ~ack_q;
    wire         wb_wr    = wb_req & wb_we_i;
    wire  [1:0]  idx      = wb_adr_i[3:2];
    wire         mapped   = (wb_adr_i[31:4] == 28'h0000000);
    wire         wr_low   = wb_wr & mapped & (idx == `TCF_IDX_LOW);
    wire         wr_high  = wb_wr & mapped & (idx == `TCF_IDX_HIGH);
    wire         wr_ctrl  = wb_wr & mapped & (idx == `TCF_IDX_CTRL);

    // Read-back images for both widths
    wire  [63:0] img64    = {mode_q, asid_q, ppn_q};
    wire  [31:0] img32    = {mode_q[0], asid_q[8:0], ppn_q[21:0]};
    wire  [31:0] rd_low   = w64_q ? img64[31:0] : img32;
    wire  [31:0] rd_high  = w64_q ? img64[63:32] : 32'h00000000;
    wire  [31:0] rd_ctrl  = {30'h00000000, full_q, w64_q};
    wire  [31:0] rd_stat  = {29'h00000000, xlate_active, discard_q,
                             ~fence_ready};
    wire  [31:0] rd_word  = ~mapped              ? 32'h00000000 :
                            idx == `TCF_IDX_LOW  ? rd_low :
                            idx == `TCF_IDX_HIGH ? rd_high :
                            idx == `TCF_IDX_CTRL ? rd_ctrl : rd_stat;

    // Byte-lane merge of write data with the current word
    logic [31:0] wmerge;
    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1)
        begin : g_lane
            assign wmerge[8*b+7:8*b] = wb_sel_i[b] ?
                wb_dat_i[8*b+7:8*b] : rd_word[8*b+7:8*b];
        end
    endgenerate

    // Candidate value: wide commits on high word, narrow on low
    wire         commit   = w64_q ? wr_high : wr_low;
    wire  [63:0] cand     = w64_q ? {wmerge, stage_low}
                                  : {32'h00000000, wmerge};
    wire  [3:0]  c_mode   = w64_q ?
        cand[`TCF_W64_MODE_HI:`TCF_W64_MODE_LO] :
        {3'h0, cand[`TCF_W32_MODE]};
    wire  [15:0] c_asid   = w64_q ?
        cand[`TCF_W64_ASID_HI:`TCF_W64_ASID_LO] :
        {7'h00, cand[`TCF_W32_ASID_HI:`TCF_W32_ASID_LO]};
    wire  [43:0] c_ppn    = w64_q ? cand[`TCF_W64_PPN_HI:0] :
        {22'h000000, cand[`TCF_W32_PPN_HI:0]};

    // Scheme support check
    wire         ok64     = (c_mode == `TCF_MODE_BARE) |
                            (c_mode == `TCF_MODE_P39) |
                            (c_mode == `TCF_MODE_P48);
    wire         ok32     = (c_mode == `TCF_MODE_BARE) |
                            (c_mode == `TCF_MODE_P32);
    wire         supp     = w64_q ? ok64 : ok32;
    wire         take     = commit & supp;

    // Space-id mask: implemented bits, low first, capped
    wire  [15:0] asid_max  = w64_q ? `TCF_ASID_MAX64 : `TCF_ASID_MAX32;
    wire  [15:0] asid_mask = `TCF_ASID_IMPL & asid_max;

    // Next register contents
    wire         w64_chg  = wr_ctrl & (wmerge[`TCF_CTRL_W64] != w64_q);
    wire  [3:0]  next_mode = w64_chg ? `TCF_MODE_BARE :
                             take    ? c_mode : mode_q;
    wire  [15:0] next_asid = take ? (c_asid & asid_mask) : asid_q;
    wire  [43:0] next_ppn  = take ? (c_ppn & `TCF_PPN_IMPL) : ppn_q;

    // Translation control register
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_q <= `TCF_MODE_BARE;
            asid_q <= 16'h0000;
            ppn_q  <= 44'h00000000000;
        end
        else
        begin
            mode_q <= next_mode;
            asid_q <= next_asid;
            ppn_q  <= next_ppn;
        end
    end

    // Low-word staging, control and discard status
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage_low <= 32'h00000000;
            w64_q     <= ctrl_reset_val[`TCF_CTRL_W64];
            full_q    <= ctrl_reset_val[`TCF_CTRL_FULL];
            discard_q <= 1'b0;
        end
        else
        begin
            if (wr_low)
                stage_low <= wmerge;
            if (wr_ctrl)
            begin
                w64_q  <= wmerge[`TCF_CTRL_W64];
                full_q <= wmerge[`TCF_CTRL_FULL];
            end
            if (commit)
                discard_q <= ~supp;
        end
    end

    // Bus answer: ack one cycle after request, data registered
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            ack_q   <= wb_req;
            rdata_q <= wb_req ? rd_word : 32'h00000000;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // Translation view: bare mode hides page and id fields
    wire         bare     = (mode_q == `TCF_MODE_BARE);
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            xlate_active           <= 1'b0;
            xlate_scheme           <= `TCF_MODE_BARE;
            root_table_page_number <= 44'h00000000000;
            xlate_space_id         <= 16'h0000;
        end
        else
        begin
            xlate_active           <= ~bare;
            xlate_scheme           <= mode_q;
            root_table_page_number <= bare ? 44'h00000000000
                                           : ppn_q;
            xlate_space_id         <= bare ? 16'h0000 : asid_q;
        end
    end

    // Fence instruction decode
    wire  [4:0]  f_rs1    = fence_instr[19:15];
    wire  [4:0]  f_rs2    = fence_instr[24:20];
    wire         is_fence = (fence_instr[6:0] == `TCF_OP_SYSTEM) &
                            (fence_instr[14:12] == `TCF_F3_PRIV) &
                            (fence_instr[11:7] == `TCF_REG_ZERO) &
                            (fence_instr[31:25] == `TCF_F7_FENCE);
    wire         accept   = fence_valid & fence_ready & is_fence;
    wire         va_zero  = (f_rs1 == `TCF_REG_ZERO);
    wire         id_zero  = (f_rs2 == `TCF_REG_ZERO);

    // Fence scope: full option widens to a global flush
    wire         s_all    = va_zero | full_q;
    wire         s_match  = ~id_zero & ~full_q;
    wire  [15:0] s_id     = fence_space_id_operand[15:0] & asid_mask;

    // Fence sequencer: drain stores, flush, report
    always_comb
    begin
        next_state = state;
        unique case (state)
            tcf_pkg::tcf_idle:
                if (accept)
                    next_state = tcf_pkg::tcf_drain;
            tcf_pkg::tcf_drain:
                if (stores_drained)
                    next_state = tcf_pkg::tcf_flush;
            tcf_pkg::tcf_flush:
                if (flush_ack)
                    next_state = tcf_pkg::tcf_done;
            tcf_pkg::tcf_done:
                next_state = tcf_pkg::tcf_idle;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            state <= tcf_pkg::tcf_idle;
        else
            state <= next_state;
    end

    // Flush scope captured at acceptance
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flush_all_levels     <= 1'b0;
            flush_match_space_id <= 1'b0;
            flush_vaddr          <= 64'h0000000000000000;
            flush_space_id       <= 16'h0000;
        end
        else if (accept)
        begin
            flush_all_levels     <= s_all;
            flush_match_space_id <= s_match;
            flush_vaddr          <= s_all ? 64'h0000000000000000
                                          : fence_vaddr_operand;
            flush_space_id       <= s_match ? s_id : 16'h0000;
        end
    end

    // Handshake outputs
    assign fence_ready = (state == tcf_pkg::tcf_idle);
    assign flush_req   = (state == tcf_pkg::tcf_flush);
    assign fence_done  = (state == tcf_pkg::tcf_done);

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    AST_DISCARD_KEEPS: assert property (
        (commit & ~supp & ~w64_chg) |=> ($stable(mode_q) &&
            $stable(asid_q) && $stable(ppn_q)))
        else $error("unsupported scheme write changed register");
    AST_WIDE_MODES: assert property (
        w64_q |-> (mode_q == `TCF_MODE_BARE ||
            mode_q == `TCF_MODE_P39 || mode_q == `TCF_MODE_P48))
        else $error("illegal wide scheme held");
    AST_NARROW_MODES: assert property (
        !w64_q |-> (mode_q[3:1] == 3'h0))
        else $error("illegal narrow scheme held");
    AST_PPN_UNIMPL: assert property (
        (ppn_q & ~`TCF_PPN_IMPL) == 44'h00000000000)
        else $error("unimplemented page bits set");
    AST_ASID_LOW: assert property (
        (asid_q & ~asid_mask) == 16'h0000)
        else $error("space id outside implemented bits");
    AST_BARE_HIDES: assert property (
        bare |=> (root_table_page_number == 44'h00000000000 &&
            xlate_space_id == 16'h0000))
        else $error("bare mode leaks fields");
    AST_DRAIN_FIRST: assert property (
        $rose(flush_req) |-> $past(stores_drained))
        else $error("flush before stores drained");
    AST_DONE_AFTER_ACK: assert property (
        (flush_req & flush_ack) |=> fence_done ##1 fence_ready)
        else $error("fence not completed after ack");
    AST_FULL_GLOBAL: assert property (
        (accept & full_q) |=> (flush_all_levels &&
            !flush_match_space_id))
        else $error("full fence option not global");
    AST_LEAF_SCOPE: assert property (
        (accept & ~va_zero & ~id_zero & ~full_q) |=>
            (!flush_all_levels && flush_match_space_id))
        else $error("leaf fence scope wrong");
    AST_ACK_ONE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    // Bus, scope, sequencer and translation register checks
    AST_ACK_NEXT: assert property (
        (wb_cyc_i & wb_stb_i & ~wb_ack_o) |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    AST_DAT_IDLE: assert property (
        !wb_ack_o |-> (wb_dat_o == 32'h00000000))
        else $error("read data shown without ack");
    AST_WRITE_NO_FLUSH: assert property (
        (commit & fence_ready) |=> !flush_req)
        else $error("register write started a flush");
    AST_IGNORE_OTHER: assert property (
        (fence_valid & fence_ready & ~is_fence) |=> fence_ready)
        else $error("non-fence word started the sequencer");
    AST_ACCEPT_BUSY: assert property (
        accept |=> (!fence_ready && !flush_req))
        else $error("fence accepted without drain step");
    AST_GLOBAL_ALL: assert property (
        (accept & va_zero & id_zero) |=> (flush_all_levels &&
            !flush_match_space_id && flush_vaddr == 64'h0000000000000000))
        else $error("global fence scope wrong");
    AST_SPACE_ALL: assert property (
        (accept & va_zero & ~id_zero & ~full_q) |=>
            (flush_all_levels && flush_match_space_id))
        else $error("space fence scope wrong");
    AST_LEAF_ALL: assert property (
        (accept & ~va_zero & id_zero & ~full_q) |=>
            (!flush_all_levels && !flush_match_space_id))
        else $error("leaf fence for all spaces scope wrong");
    AST_SID_MASKED: assert property (
        (flush_space_id & ~`TCF_ASID_IMPL) == 16'h0000)
        else $error("flush space id outside implemented bits");
    AST_XLATE_ON: assert property (
        (mode_q != `TCF_MODE_BARE) |=> xlate_active)
        else $error("translation not shown active");
    AST_FLUSH_HOLD: assert property (
        (flush_req & ~flush_ack) |=> flush_req)
        else $error("flush request dropped before ack");
    AST_ASID_CAP: assert property (
        (asid_q & ~asid_max) == 16'h0000)
        else $error("space id above maximum width");
    AST_SCOPE_HOLD: assert property (
        ~accept |=> ($stable(flush_vaddr) && $stable(flush_space_id)))
        else $error("flush scope changed without a fence");
    AST_DONE_PULSE: assert property (
        fence_done |=> !fence_done)
        else $error("fence done held longer than one cycle");
    AST_BUSY_FLUSH: assert property (
        flush_req |-> !fence_ready)
        else $error("sequencer ready during flush");

endmodule // tcf_translation_control

// ===== verification/tcf_pipe_model.sv
`timescale 1ns/100ps
module tcf_pipe_model (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic flush_req,
    output logic      stores_drained,
    output logic      flush_ack
);
    logic [2:0] wait_cnt;

    // Store drain and cache flush with random latency
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wait_cnt <= 3'h0;
            stores_drained <= 1'b0;
            flush_ack <= 1'b0;
        end
        else
        begin
            stores_drained <= ($urandom % 3) != 0;
            flush_ack <= 1'b0;
            if (flush_req && !flush_ack && wait_cnt == 3'h0)
            begin
                flush_ack <= 1'b1;
                wait_cnt <= 3'($urandom % 5);
            end
            else if (flush_req && wait_cnt != 3'h0)
                wait_cnt <= wait_cnt - 3'h1;
        end
    end
endmodule // tcf_pipe_model

// ===== verification/tcf_translation_control_tb_top.sv
`timescale 1ns/100ps
`include "tcf_consts.svh"
module tcf_translation_control_tb_top;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [31:0] wb_adr_i = 32'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0]  wb_sel_i = 4'hF;
    logic        wb_we_i = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        fence_valid = 1'b0;
    logic [31:0] fence_instr = 32'h0;
    logic [63:0] fence_vaddr_operand = 64'h0;
    logic [63:0] fence_space_id_operand = 64'h0;
    logic [31:0] wb_dat_o, rdata;
    logic        wb_ack_o, fence_ready, fence_done, stores_drained;
    logic        flush_req, flush_ack, flush_all_levels;
    logic        flush_match_space_id, xlate_active;
    logic [63:0] flush_vaddr, va;
    logic [15:0] flush_space_id, xlate_space_id, m_id;
    logic [3:0]  xlate_scheme, m_mode, md;
    logic [43:0] root_table_page_number, m_ppn;
    logic [4:0]  r1, r2;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    tcf_translation_control tcf_translation_control_inst (
        .core_clk, .rst_b, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
        .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .fence_valid,
        .fence_instr, .fence_vaddr_operand, .fence_space_id_operand,
        .fence_ready, .fence_done, .stores_drained, .flush_req,
        .flush_ack, .flush_all_levels, .flush_match_space_id,
        .flush_vaddr, .flush_space_id, .xlate_active, .xlate_scheme,
        .root_table_page_number, .xlate_space_id
    );
    tcf_pipe_model tcf_pipe_model_inst (
        .core_clk, .rst_b, .flush_req, .stores_drained, .flush_ack
    );

    // Clock
    initial
    begin
        forever #25 core_clk = ~core_clk;
    end

    // Hang guard
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Classic single Wishbone cycle, held until ack
    task automatic wb(input logic [31:0] a, input logic we,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 50)
            num_errors++;
    endtask

    function automatic logic ok64(input logic [3:0] m);
        return m == 4'h0 || m == 4'h8 || m == 4'h9;
    endfunction

    // Wide commit: low word stages, high word commits
    task automatic set64(input logic [3:0] m, input logic [15:0] id,
                         input logic [43:0] p);
        wb(32'h0, 1'b1, p[31:0]);
        wb(32'h4, 1'b1, {m, id, p[43:32]});
        chk("no flush", flush_req, 1'b0);
        if (ok64(m))
        begin
            m_mode = m;
            m_id = id;
            m_ppn = p;
        end
    endtask

    task automatic chk_state;
        logic b;
        @(posedge core_clk);
        b = m_mode == 4'h0;
        chk("scheme", xlate_scheme, m_mode);
        chk("active", xlate_active, !b);
        chk("root", root_table_page_number,
            b ? 44'h0 : m_ppn & `TCF_PPN_IMPL);
        chk("space", xlate_space_id,
            b ? 16'h0 : m_id & `TCF_ASID_IMPL);
    endtask

    // Offer one fence-format word; wait for completion only when rd is zero
    task automatic fence(input logic full, input logic [4:0] rd);
        int n;
        n = 0;
        @(posedge core_clk);
        fence_instr <= {`TCF_F7_FENCE, r2, r1, `TCF_F3_PRIV, rd,
                        `TCF_OP_SYSTEM};
        fence_valid <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (fence_ready !== 1'b1 && n < 50);
        fence_valid <= 1'b0;
        while (fence_done !== 1'b1 && n < 100 && rd == 5'h0)
        begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 100)
            num_errors++;
        @(posedge core_clk);
        if (rd != 5'h0)
            chk("ignored", {fence_ready, flush_req}, 2'h2);
        else
        begin
            chk("all", flush_all_levels, r1 == 0 || full);
            chk("match", flush_match_space_id,
                r2 != 0 && !full);
            chk("vaddr", flush_vaddr,
                (r1 == 0 || full) ? 64'h0 : va);
            chk("sid", flush_space_id, (r2 != 0 && !full) ?
                fence_space_id_operand[15:0] & `TCF_ASID_IMPL : 16'h0);
        end
    endtask

    initial
    begin
        md = 4'($urandom(19));
        m_mode = 4'h0;
        m_id = 16'h0;
        m_ppn = 44'h0;
        repeat (4) @(posedge core_clk);
        chk("ready", {fence_ready, xlate_active}, 2'h2);
        rst_b <= 1'b1;
        wb(32'h8, 1'b0, 32'h0);
        chk("ctrl", rdata, 32'h1);
        wb(32'h4, 1'b0, 32'h0);
        chk("high", rdata, 32'h0);
        $display("test reset done");
        set64(4'h8, 16'hFFFF, 44'hFFFFFFFFFFF);
        chk_state();
        wb(32'h4, 1'b0, 32'h0);
        chk("high", rdata, {4'h8, 16'h007F, 12'h0});
        wb(32'h0, 1'b0, 32'h0);
        chk("low", rdata, 32'h003FFFFF);
        for (int i = 0; i < 14; i++)
        begin
            md = i < 8 ? 4'(32'h9A1B7FC0 >> (4 * i)) : 4'($urandom);
            set64(md, 16'($urandom), 44'({$urandom, $urandom}));
            chk_state();
            wb(32'hC, 1'b0, 32'h0);
            chk("disc", rdata[2:1], {m_mode != 0, !ok64(md)});
        end
        wb(32'h10, 1'b1, 32'hFFFFFFFF);
        wb(32'h10, 1'b0, 32'h0);
        chk("unmapped", rdata, 32'h0);
        chk_state();
        $display("test wide done");
        wb(32'h8, 1'b1, 32'h0);
        m_mode = 4'h0;
        chk_state();
        wb(32'h0, 1'b1, 32'hFFFFFFFF);
        {m_mode, m_id, m_ppn} = {4'h1, 16'h01FF, 44'h3FFFFF};
        chk_state();
        wb(32'h4, 1'b0, 32'h0);
        chk("narrow high", rdata, 32'h0);
        wb(32'h0, 1'b1, 32'h7FFFFFFF);
        m_mode = 4'h0;
        chk_state();
        wb(32'h8, 1'b1, 32'h1);
        $display("test narrow done");
        for (int k = 0; k < 16; k++)
        begin
            wb(32'h8, 1'b1, {30'h0, k[2], 1'b1});
            r1 = k[0] ? 5'(1 + $urandom % 31) : 5'h0;
            r2 = k[1] ? 5'(1 + $urandom % 31) : 5'h0;
            va = k[0] ? {$urandom, $urandom} | 64'h1 : 64'h0;
            fence_vaddr_operand <= va;
            fence_space_id_operand <= k[1] ? {$urandom, $urandom} : 64'h0;
            fence(k[2], k[3] ? 5'h0 : 5'(k + 1));
        end
        $display("test fence done");
        end_of_test();
    end
endmodule // tcf_translation_control_tb_top
